// ### step_interp_pkg.sv
// Constants, register map and carrier types for the step-pulse interpolator
package step_interp_pkg;

    // ----------------------------------------
    // Bus and field widths
    // ----------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int POS_W = 10;
    localparam int PER_W = 21;
    localparam int CUR_W = 5;
    localparam int STST_MAX_LOG2 = 20;
    localparam int TMR_OPTIONS_LOG2 = 3;
    localparam logic [3:0] RES_MAX = 4'h8;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [ADDR_W-1:0] CHOP_CFG_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] DRV_CFG_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] CUR_CFG_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h0C;
    localparam logic [ADDR_W-1:0] INT_STATUS_OFS = 8'h10;
    localparam logic [ADDR_W-1:0] INT_MASK_OFS = 8'h14;
    localparam logic [ADDR_W-1:0] PERIOD_OFS = 8'h18;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int CHOP_INTPOL_BIT = 0;
    localparam int CHOP_DEDGE_BIT = 1;
    localparam int CHOP_RES_LSB = 4;
    localparam int DRV_STST_TIME_LSB = 0;
    localparam int CUR_HOLD_LSB = 0;
    localparam int CUR_RUN_LSB = 8;
    localparam int STAT_POS_LSB = 0;
    localparam int STAT_STST_BIT = 16;
    localparam int STAT_CUR_LSB = 24;
    localparam int IRQ_STST_SET_BIT = 0;
    localparam int IRQ_STST_CLR_BIT = 1;

    // ----------------------------------------
    // Values after reset
    // ----------------------------------------
    localparam logic RST_INTPOL = 1'b1;
    localparam logic RST_DEDGE = 1'b0;
    localparam logic [3:0] RST_RES = 4'h8;
    localparam logic [2:0] RST_STST_TIME = 3'h7;
    localparam logic [CUR_W-1:0] RST_HOLD = 5'h08;
    localparam logic [CUR_W-1:0] RST_RUN = 5'h1F;
    localparam logic [1:0] RST_INT_MASK = 2'h0;

    // ----------------------------------------
    // Carrier types
    // ----------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic write;
        logic [DATA_W-1:0] wdata;
    } apb_req_t;

    typedef struct packed {
        logic intpol;
        logic dedge;
        logic [3:0] res;
    } chop_cfg_t;

endpackage

// ### step_interpolator.sv
// Step-pulse interpolator with standstill detection and APB register slave
`timescale 1ns/100ps
`default_nettype none
module step_interpolator
    import step_interp_pkg::*;
#(
    parameter int STANDSTILL_MAX_LOG2 = STST_MAX_LOG2
)
(
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic step_in,
    input wire logic dir_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ADDR_W-1:0] paddr_in,
    input wire logic [DATA_W-1:0] pwdata_in,
    output logic [DATA_W-1:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    output logic irq_out,
    output logic [POS_W-1:0] position_out,
    output logic microstep_out,
    output logic standstill_out,
    output logic [CUR_W-1:0] current_level_out
);

    // ----------------------------------------
    // Parameter check
    // ----------------------------------------
    if (STANDSTILL_MAX_LOG2 < 8 || STANDSTILL_MAX_LOG2 > STST_MAX_LOG2)
    begin : g_bad_timer
        $error("STANDSTILL_MAX_LOG2 must lie in 8..20");
    end

    if (PER_W <= STANDSTILL_MAX_LOG2)
    begin : g_bad_width
        $error("period counter too narrow for the standstill timer");
    end

    // ----------------------------------------
    // Derived constants
    // ----------------------------------------
    localparam logic [4:0] TMR_BASE = 5'(STANDSTILL_MAX_LOG2 - (1 << TMR_OPTIONS_LOG2) + 1);
    localparam logic [PER_W-1:0] PERIOD_CAP = PER_W'(1) << STANDSTILL_MAX_LOG2;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [POS_W-1:0] move_pos(input logic [POS_W-1:0] pos,
                                                   input logic [8:0] delta,
                                                   input logic dir);
        logic [POS_W-1:0] d;
        d = POS_W'(delta);
        move_pos = dir ? pos - d : pos + d;
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic step_meta;
    logic step_sync;
    logic step_prev;
    logic dir_meta;
    logic dir_sync;
    chop_cfg_t chop_cfg;
    logic [2:0] stst_time;
    logic [CUR_W-1:0] hold_current_level;
    logic [CUR_W-1:0] run_level;
    logic [1:0] int_status;
    logic [1:0] int_mask;
    logic [PER_W-1:0] period_cnt;
    logic [PER_W-1:0] last_period;
    logic [PER_W-1:0] burst_interval;
    logic [PER_W-1:0] tick_cnt;
    logic [8:0] burst_left;
    logic burst_dir;

    // ----------------------------------------
    // Step edge detection
    // ----------------------------------------
    wire step_rise = step_sync & ~step_prev;
    wire step_fall = ~step_sync & step_prev;
    wire active_edge = step_rise | (chop_cfg.dedge & step_fall);
    wire [3:0] res_eff = (chop_cfg.res > RES_MAX) ? RES_MAX : chop_cfg.res;
    wire [8:0] step_width = 9'h001 << res_eff;

    // ----------------------------------------
    // Period measurement and standstill
    // ----------------------------------------
    wire [4:0] tmr_shift = TMR_BASE + {2'h0, stst_time};
    wire [PER_W-1:0] timeout = PER_W'(1) << tmr_shift;
    // Count holds at the cap for slow step rates
    wire period_full = (period_cnt >= PERIOD_CAP);
    wire [PER_W-1:0] next_period_cnt = active_edge ? PER_W'(1)
                                     : (period_full ? period_cnt : period_cnt + PER_W'(1));
    wire next_standstill = active_edge ? 1'b0
                         : ((period_cnt >= timeout) ? 1'b1 : standstill_out);
    wire stst_enter = next_standstill & ~standstill_out;
    wire stst_leave = standstill_out & ~next_standstill;

    // ----------------------------------------
    // Microstep timing
    // ----------------------------------------
    wire [PER_W-1:0] raw_interval = period_cnt >> res_eff;
    // Interval never drops below one clock
    wire [PER_W-1:0] next_interval = (raw_interval == '0) ? PER_W'(1) : raw_interval;
    wire micro_due = (burst_left != 9'h000) && (tick_cnt == '0);
    wire direct_step = active_edge & ~chop_cfg.intpol;
    wire burst_start = active_edge & chop_cfg.intpol;
    wire do_micro = micro_due & ~active_edge;
    wire [POS_W-1:0] next_position = direct_step ? move_pos(position_out, step_width, dir_sync)
                                   : (do_micro ? move_pos(position_out, 9'h001, burst_dir)
                                   : position_out);
    wire [CUR_W-1:0] next_current = next_standstill ? hold_current_level : run_level;

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    apb_req_t req;
    assign req = '{addr: paddr_in, write: pwrite_in, wdata: pwdata_in};
    wire access = psel_in & penable_in;
    wire hit_chop = (req.addr == CHOP_CFG_OFS);
    wire hit_drv = (req.addr == DRV_CFG_OFS);
    wire hit_cur = (req.addr == CUR_CFG_OFS);
    wire hit_stat = (req.addr == STATUS_OFS);
    wire hit_ist = (req.addr == INT_STATUS_OFS);
    wire hit_imask = (req.addr == INT_MASK_OFS);
    wire hit_per = (req.addr == PERIOD_OFS);
    wire addr_hit = hit_chop | hit_drv | hit_cur | hit_stat | hit_ist | hit_imask | hit_per;
    // Status and period words accept writes and drop them
    wire wr_en = access & pready_out & req.write & addr_hit;

    // ----------------------------------------
    // Interrupt status, set wins over clear
    // ----------------------------------------
    wire [1:0] w1c = (wr_en & hit_ist)
                   ? {req.wdata[IRQ_STST_CLR_BIT], req.wdata[IRQ_STST_SET_BIT]} : 2'h0;
    wire [1:0] next_int_status = (int_status & ~w1c)
                               | {stst_leave, stst_enter};

    // ----------------------------------------
    // Register read mux
    // ----------------------------------------
    wire [1:0] chop_bits = {chop_cfg.dedge, chop_cfg.intpol};
    wire [DATA_W-1:0] chop_word = (DATA_W'(chop_cfg.res) << CHOP_RES_LSB)
                                | DATA_W'(chop_bits);
    wire [DATA_W-1:0] drv_word = DATA_W'(stst_time) << DRV_STST_TIME_LSB;
    wire [DATA_W-1:0] cur_word = (DATA_W'(run_level) << CUR_RUN_LSB)
                               | (DATA_W'(hold_current_level) << CUR_HOLD_LSB);
    wire [DATA_W-1:0] stat_word = (DATA_W'(current_level_out) << STAT_CUR_LSB)
                                | (DATA_W'(standstill_out) << STAT_STST_BIT)
                                | (DATA_W'(position_out) << STAT_POS_LSB);
    wire [DATA_W-1:0] rd_word = hit_chop ? chop_word
                              : hit_drv ? drv_word
                              : hit_cur ? cur_word
                              : hit_stat ? stat_word
                              : hit_ist ? DATA_W'(int_status)
                              : hit_imask ? DATA_W'(int_mask)
                              : hit_per ? DATA_W'(last_period)
                              : '0;

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    always_ff @(posedge ref_clk_in)
    begin
        if (sys_rst_in)
        begin
            step_meta <= 1'b0;
            step_sync <= 1'b0;
            step_prev <= 1'b0;
            dir_meta <= 1'b0;
            dir_sync <= 1'b0;
        end
        else
        begin
            step_meta <= step_in;
            step_sync <= step_meta;
            step_prev <= step_sync;
            dir_meta <= dir_in;
            dir_sync <= dir_meta;
        end
    end

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    always_ff @(posedge ref_clk_in)
    begin
        if (sys_rst_in)
        begin
            chop_cfg <= '{intpol: RST_INTPOL, dedge: RST_DEDGE, res: RST_RES};
            stst_time <= RST_STST_TIME;
            hold_current_level <= RST_HOLD;
            run_level <= RST_RUN;
            int_mask <= RST_INT_MASK;
        end
        else if (wr_en)
        begin
            if (hit_chop)
            begin
                chop_cfg.intpol <= req.wdata[CHOP_INTPOL_BIT];
                chop_cfg.dedge <= req.wdata[CHOP_DEDGE_BIT];
                chop_cfg.res <= req.wdata[CHOP_RES_LSB +: 4];
            end
            if (hit_drv)
                stst_time <= req.wdata[DRV_STST_TIME_LSB +: 3];
            if (hit_cur)
            begin
                hold_current_level <= req.wdata[CUR_HOLD_LSB +: CUR_W];
                run_level <= req.wdata[CUR_RUN_LSB +: CUR_W];
            end
            if (hit_imask)
                int_mask <= req.wdata[1:0];
        end
    end

    // ----------------------------------------
    // Period counter, standstill and current
    // ----------------------------------------
    always_ff @(posedge ref_clk_in)
    begin
        if (sys_rst_in)
        begin
            period_cnt <= '0;
            last_period <= '0;
            standstill_out <= 1'b0;
            current_level_out <= RST_RUN;
            int_status <= 2'h0;
            irq_out <= 1'b0;
        end
        else
        begin
            period_cnt <= next_period_cnt;
            if (active_edge)
                last_period <= period_cnt;
            standstill_out <= next_standstill;
            current_level_out <= next_current;
            int_status <= next_int_status;
            irq_out <= |(next_int_status & int_mask);
        end
    end

    // ----------------------------------------
    // Burst generator and sequencer position
    // ----------------------------------------
    always_ff @(posedge ref_clk_in)
    begin
        if (sys_rst_in)
        begin
            burst_left <= 9'h000;
            burst_interval <= PER_W'(1);
            tick_cnt <= '0;
            burst_dir <= 1'b0;
            position_out <= '0;
            microstep_out <= 1'b0;
        end
        else
        begin
            // A new edge restarts the burst; unissued microsteps are dropped
            if (burst_start)
            begin
                burst_left <= step_width;
                burst_interval <= next_interval;
                tick_cnt <= '0;
                burst_dir <= dir_sync;
            end
            else if (micro_due)
            begin
                burst_left <= burst_left - 9'h001;
                tick_cnt <= burst_interval - PER_W'(1);
            end
            else if (tick_cnt != '0)
                tick_cnt <= tick_cnt - PER_W'(1);
            position_out <= next_position;
            microstep_out <= do_micro | direct_step;
        end
    end

    // ----------------------------------------
    // APB answer
    // ----------------------------------------
    always_ff @(posedge ref_clk_in)
    begin
        if (sys_rst_in)
        begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= '0;
        end
        else
        begin
            pready_out <= access & ~pready_out;
            pslverr_out <= access & ~pready_out & ~addr_hit;
            prdata_out <= (access & ~pready_out & ~req.write) ? rd_word : '0;
        end
    end

endmodule // step_interpolator
`default_nettype wire

// ### step_src_model.sv
// Motion controller model: frames of 50% duty step pulses
`timescale 1ns/100ps
`default_nettype none
module step_src_model
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic go_in,
    input wire logic dir_cmd_in,
    input wire logic [15:0] half_in,
    input wire logic [7:0] count_in,
    output logic step_out,
    output logic dir_out,
    output logic busy_out
);
    logic [15:0] tick;
    logic [8:0] edges_left;
    // Direction set half a period before the first edge; step idles low
    always @(posedge clk_in)
    begin
        if (rst_in)
        begin
            step_out <= 1'b0;
            dir_out <= 1'b0;
            busy_out <= 1'b0;
            tick <= 16'h0001;
            edges_left <= 9'h000;
        end
        else if (!busy_out && go_in)
        begin
            busy_out <= 1'b1;
            dir_out <= dir_cmd_in;
            tick <= 16'h0001;
            edges_left <= {count_in, 1'b0};
        end
        else if (busy_out && tick == half_in)
        begin
            tick <= 16'h0001;
            step_out <= ~step_out;
            edges_left <= edges_left - 9'h001;
            busy_out <= edges_left != 9'h001;
        end
        else if (busy_out)
            tick <= tick + 16'h0001;
    end
endmodule // step_src_model
`default_nettype wire

// ### step_interpolator_chk.sv
// Port-level assertions for the step interpolator
`timescale 1ns/100ps
`default_nettype none
module step_interpolator_chk
    import step_interp_pkg::*;
#(
    parameter int STANDSTILL_MAX_LOG2 = STST_MAX_LOG2
)
(
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic step_in,
    input wire logic dir_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ADDR_W-1:0] paddr_in,
    input wire logic [DATA_W-1:0] pwdata_in,
    input wire logic [DATA_W-1:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic irq_out,
    input wire logic [POS_W-1:0] position_out,
    input wire logic microstep_out,
    input wire logic standstill_out,
    input wire logic [CUR_W-1:0] current_level_out
);
    localparam int QUIET_LIM = (1 << STANDSTILL_MAX_LOG2) + 16;
    logic [POS_W-1:0] prev_pos;
    logic prev_step;
    logic edge_dir;
    int quiet_cnt;
    wire logic [POS_W-1:0] up_delta;
    wire logic [POS_W-1:0] dn_delta;
    wire logic up_ok;
    wire logic dn_ok;
    assign up_delta = position_out - prev_pos;
    assign dn_delta = prev_pos - position_out;
    assign up_ok = up_delta != 0 && up_delta <= 10'h100 && (up_delta & (up_delta - 1'b1)) == 0;
    assign dn_ok = dn_delta != 0 && dn_delta <= 10'h100 && (dn_delta & (dn_delta - 1'b1)) == 0;
    always_ff @(posedge ref_clk_in)
    begin
        prev_pos <= position_out;
        prev_step <= step_in;
        edge_dir <= (step_in != prev_step) ? dir_in : edge_dir;
    end
    // Cycles since the step pin last moved
    always_ff @(posedge ref_clk_in)
    begin
        if (sys_rst_in || step_in != prev_step)
            quiet_cnt <= 0;
        else if (quiet_cnt < QUIET_LIM)
            quiet_cnt <= quiet_cnt + 1;
    end
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (sys_rst_in);
    a_pos_on_microstep: assert property ($changed(position_out) |-> microstep_out)
        else $error("position moved without a microstep pulse");
    a_up_step_width: assert property (microstep_out && !edge_dir |-> up_ok)
        else $error("forward microstep has a wrong width");
    a_down_step_width: assert property (microstep_out && edge_dir |-> dn_ok)
        else $error("reverse microstep has a wrong width");
    a_stst_clears: assert property (standstill_out && $rose(step_in) |-> ##[2:6] !standstill_out)
        else $error("standstill not cleared by a step edge");
    a_no_early_stst: assert property ($rose(step_in) |-> ##6 (!standstill_out) [*4])
        else $error("standstill flagged right after a step edge");
    a_stst_timeout: assert property (quiet_cnt == QUIET_LIM |-> standstill_out)
        else $error("standstill missing after the longest timeout");
    a_hold_current: assert property ($changed(standstill_out) |-> $changed(current_level_out))
        else $error("current level did not follow standstill");
    a_apb_one_wait: assert property ($rose(psel_in && penable_in) |=> pready_out)
        else $error("ready not given after one wait state");
    a_err_with_ready: assert property (pslverr_out |-> pready_out)
        else $error("error response without ready");
    c_reverse: cover property (microstep_out && edge_dir);
    c_standstill: cover property ($rose(standstill_out));
    c_bus_error: cover property (pready_out && pslverr_out);
endmodule // step_interpolator_chk
bind step_interpolator step_interpolator_chk #(.STANDSTILL_MAX_LOG2(STANDSTILL_MAX_LOG2)) u_chk (
    .ref_clk_in, .sys_rst_in, .step_in, .dir_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .irq_out, .position_out, .microstep_out,
    .standstill_out, .current_level_out);
`default_nettype wire

// ### step_interpolator_test.sv
// Self-checking testbench for the step interpolator
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin failures++; $display("Error at %0t: got %0h, expected %0h", $time, (a), (e)); end end
module step_interpolator_test
    import step_interp_pkg::*;
;
    logic ref_clk_in, sys_rst_in, step_in, dir_in, psel_in, penable_in, pwrite_in, go, sdir, busy;
    logic pready_out, pslverr_out, irq_out, microstep_out, standstill_out, err, prev_stst;
    logic [ADDR_W-1:0] paddr_in;
    logic [DATA_W-1:0] pwdata_in, prdata_out, rd;
    logic [POS_W-1:0] position_out, exp_pos;
    logic [CUR_W-1:0] current_level_out;
    logic [15:0] shalf;
    logic [7:0] scount;
    int failures = 0, checks = 0, cyc = 0, ms_cnt = 0, ms_last = 0, ms_gap = 0, st_fall = 0, st_len = 0, m0;
    step_interpolator #(.STANDSTILL_MAX_LOG2(10)) u_dut (.ref_clk_in, .sys_rst_in, .step_in, .dir_in,
        .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
        .pslverr_out, .irq_out, .position_out, .microstep_out, .standstill_out, .current_level_out);
    step_src_model u_src (.clk_in(ref_clk_in), .rst_in(sys_rst_in), .go_in(go),
        .dir_cmd_in(sdir), .half_in(shalf), .count_in(scount), .step_out(step_in),
        .dir_out(dir_in), .busy_out(busy));
    initial
    begin
        ref_clk_in = 1'b0;
        forever #50 ref_clk_in = ~ref_clk_in;
    end
    // ----------------------------------------
    // Microstep spacing and standstill-clear to standstill-set delay monitor
    // ----------------------------------------
    always @(posedge ref_clk_in)
    begin
        cyc <= cyc + 1;
        prev_stst <= standstill_out;
        if (microstep_out === 1'b1)
        begin
            ms_cnt <= ms_cnt + 1;
            ms_gap <= cyc - ms_last;
            ms_last <= cyc;
        end
        if (standstill_out === 1'b1 && prev_stst === 1'b0)
            st_len <= cyc - st_fall;
        if (standstill_out === 1'b0 && prev_stst === 1'b1)
            st_fall <= cyc;
    end
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd);
        int n;
        n = 0;
        @(posedge ref_clk_in);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= wd;
        @(posedge ref_clk_in);
        penable_in <= 1'b1;
        do
        begin
            @(posedge ref_clk_in);
            n++;
        end
        while (pready_out !== 1'b1 && n < 20);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        `CHK(n < 20, 1'b1)
    endtask
    task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask
    task automatic irqchk(input logic e);
        repeat (2) @(posedge ref_clk_in);
        `CHK(irq_out, e)
    endtask
    // Sends a frame of steps, then waits for standstill to settle
    task automatic run_steps(input logic [15:0] h, input logic [7:0] n, input logic d);
        int k;
        k = 0;
        @(posedge ref_clk_in);
        shalf <= h;
        scount <= n;
        sdir <= d;
        go <= 1'b1;
        @(posedge ref_clk_in);
        go <= 1'b0;
        @(posedge ref_clk_in);
        while ((busy === 1'b1 || standstill_out !== 1'b1) && k < 20000)
        begin
            @(posedge ref_clk_in);
            k++;
        end
        repeat (8) @(posedge ref_clk_in);
        `CHK(k < 20000, 1'b1)
    endtask
    task automatic report_and_stop();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        repeat (60000) @(posedge ref_clk_in);
        failures++;
        report_and_stop();
    end
    initial
    begin
        sys_rst_in = 1'b1;
        psel_in = 1'b0;
        penable_in = 1'b0;
        pwrite_in = 1'b0;
        paddr_in = 8'h00;
        pwdata_in = 32'h0;
        go = 1'b0;
        sdir = 1'b0;
        shalf = 16'h0001;
        scount = 8'h00;
        exp_pos = 10'h000;
        repeat (20) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        @(posedge ref_clk_in);
        `CHK(current_level_out, RST_RUN)
        rdchk(CHOP_CFG_OFS, {24'h0, RST_RES, 2'b00, RST_DEDGE, RST_INTPOL});
        rdchk(DRV_CFG_OFS, {29'h0, RST_STST_TIME});
        rdchk(CUR_CFG_OFS, {19'h0, RST_RUN, 3'h0, RST_HOLD});
        rdchk(INT_MASK_OFS, 32'h0);
        apb(1'b0, 8'h1C, 32'h0);
        `CHK({err, rd}, {1'b1, 32'h0})
        apb(1'b1, STATUS_OFS, 32'hFFFFFFFF);
        `CHK(err, 1'b0)
        for (int r = 0; r <= 8; r++)
        begin
            apb(1'b1, CHOP_CFG_OFS, {24'h0, r[3:0], 4'h0});
            run_steps(16'h0014, 8'h01, 1'b0);
            exp_pos = exp_pos + (10'h001 << r);
            `CHK(position_out, exp_pos)
        end
        run_steps(16'h0014, 8'h03, 1'b1);
        exp_pos = exp_pos - 10'h300;
        `CHK(position_out, exp_pos)
        for (int d = 0; d < 2; d++)
        begin
            apb(1'b1, CHOP_CFG_OFS, {30'h0, d[0], 1'b0});
            run_steps(16'h0014, 8'h03, 1'b0);
            exp_pos = exp_pos + (d ? 10'h006 : 10'h003);
            `CHK(position_out, exp_pos)
        end
        apb(1'b1, CHOP_CFG_OFS, 32'h11);
        m0 = ms_cnt;
        run_steps(16'h0032, 8'h04, 1'b0);
        exp_pos = exp_pos + 10'h007;
        `CHK(position_out, exp_pos)
        `CHK(ms_cnt - m0, 7)
        `CHK(ms_gap, 50)
        apb(1'b1, CHOP_CFG_OFS, 32'h81);
        m0 = ms_cnt;
        run_steps(16'h0226, 8'h02, 1'b0);
        exp_pos = exp_pos + 10'h200;
        `CHK(position_out, exp_pos)
        `CHK(ms_cnt - m0, 512)
        `CHK(ms_gap, 4)
        `CHK(current_level_out, RST_HOLD)
        rdchk(STATUS_OFS, {3'h0, RST_HOLD, 7'h00, 1'b1, 6'h00, exp_pos});
        rdchk(PERIOD_OFS, 32'h400);
        apb(1'b1, INT_STATUS_OFS, 32'h3);
        rdchk(INT_STATUS_OFS, 32'h0);
        apb(1'b1, INT_MASK_OFS, 32'h1);
        irqchk(1'b0);
        apb(1'b1, CHOP_CFG_OFS, 32'h80);
        run_steps(16'h0014, 8'h01, 1'b0);
        irqchk(1'b1);
        rdchk(INT_STATUS_OFS, 32'h3);
        apb(1'b1, INT_MASK_OFS, 32'h0);
        irqchk(1'b0);
        apb(1'b1, INT_MASK_OFS, 32'h2);
        irqchk(1'b1);
        apb(1'b1, INT_STATUS_OFS, 32'h2);
        irqchk(1'b0);
        exp_pos = exp_pos + 10'h100;
        for (int s = 0; s < 8; s++)
        begin
            apb(1'b1, DRV_CFG_OFS, {29'h0, s[2:0]});
            run_steps(16'h0014, 8'h01, 1'b0);
            exp_pos = exp_pos + 10'h100;
            `CHK(st_len >= (8 << s) - 2 && st_len <= (8 << s) + 2, 1'b1)
        end
        `CHK(position_out, exp_pos)
        report_and_stop();
    end
endmodule // step_interpolator_test
`default_nettype wire
